// file: logic/acm_defs.svh
/*
 * Offsets, field positions and reset values for the current channel mapping block.
 * Assumes inclusion by the principal design file only; the package needs none of it.
 */
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH

// ==========================================================
// Register indices (word addressed)
`define ACM_ADDR_W            8
`define ACM_OFS_MAPPING       8'h0a
`define ACM_OFS_EXT_SAMPLES   8'h0b
`define ACM_OFS_STAGE_CFG     8'h0c

// ==========================================================
// Mapping register fields
`define ACM_RAW1_LSB          8
`define ACM_RAW1_MSB          15
`define ACM_UX_LSB            24
`define ACM_UX_MSB            25
`define ACM_V_LSB             26
`define ACM_V_MSB             27
`define ACM_WY_LSB            28
`define ACM_WY_MSB            29
`define ACM_MAPPING_RST       32'h2400_0100
`define ACM_MAPPING_MASK      32'h3fff_ff00

// ==========================================================
// External sample register fields
`define ACM_EXT0_LSB          0
`define ACM_EXT0_MSB          15
`define ACM_EXT1_LSB          16
`define ACM_EXT1_MSB          31
`define ACM_EXT_RST           32'h0000_0000

// ==========================================================
// Input stage register fields
`define ACM_STAGE0_LSB        0
`define ACM_STAGE0_MSB        3
`define ACM_STAGE_RST         32'h0000_0000
`define ACM_STAGE_MASK        32'h0000_000f

`endif

// file: logic/acm_pkg.sv
/*
 * Types for the current channel mapping block.
 * Needs nothing from acm_defs.svh; it includes no file.
 */
package acm_pkg;

	// ==========================================================
	// Channel codes of the phase mapping fields
	typedef enum logic [1:0]
	{
		ACM_CH_ZERO,
		ACM_CH_ONE,
		ACM_CH_TWO,
		ACM_CH_RSVD
	} acm_chan_e;

	// Input stage codes of channel zero
	typedef enum logic [3:0]
	{
		ACM_STG_POS_NEG,
		ACM_STG_GND_NEG,
		ACM_STG_QUARTER,
		ACM_STG_THREE_QTR,
		ACM_STG_POS_GND
	} acm_stage_e;

	// Register access request
	typedef struct packed
	{
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} acm_req_s;

	// Routed phase currents
	typedef struct packed
	{
		logic [15:0] ux;
		logic [15:0] v;
		logic [15:0] wy;
		logic [15:0] raw_one;
	} acm_phase_s;

endpackage

// file: logic/acm_channel_map.sv
/*
 * Current channel mapping: phase routing, external sample registers and the
 * channel-zero input stage configuration, reached by the device register port.
 * Assumes register requests and converter samples come from logic on ref_clk.
 */
// Notes on behaviour
// - The V phase current comes from the channel picked by bits 27:26, reset code 1.
// - The WY phase current comes from the channel picked by bits 29:28, reset code 2.
// - Bits 15:0 of the external register hold a writable channel-zero sample.
// - Bits 31:16 of the same register hold a writable channel-one sample.
// - Bits 3:0 of the stage register set the channel-zero input stage mode.
// - The UX phase current comes from the channel picked by bits 25:24, reset code 0.
// - Bits 15:8 pick the raw channel-one source among two internal and two external.
`timescale 1ns/1ps
`include "acm_defs.svh"

module acm_channel_map
	import acm_pkg::*;
#(
	parameter int SAMPLE_W = 16
)
(
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire acm_req_s            reg_req,
	input  wire logic                reg_valid,
	output logic [31:0]              reg_rdata,
	output logic                     reg_rvalid,
	input  wire logic [SAMPLE_W-1:0] sd_raw_zero,
	input  wire logic [SAMPLE_W-1:0] sd_raw_one,
	input  wire logic [SAMPLE_W-1:0] current_channel_two,
	output acm_phase_s               phase_out,
	output acm_stage_e               stage_zero_mode
);

	// ==========================================================
	// Register file
	logic [31:0] mapping_reg;
	logic [31:0] ext_reg;
	logic [31:0] stage_reg;
	logic [31:0] rdata_reg;
	logic        rvalid_reg;
	acm_phase_s  phase_reg;
	acm_stage_e  stage_mode_reg;

	// Address decode
	wire logic hit_map   = reg_req.addr == `ACM_OFS_MAPPING;
	wire logic hit_ext   = reg_req.addr == `ACM_OFS_EXT_SAMPLES;
	wire logic hit_stage = reg_req.addr == `ACM_OFS_STAGE_CFG;
	wire logic do_wr     = reg_valid & reg_req.wr;

	// Unmapped index reads zero
	wire logic [31:0] rdata_next = hit_map ? mapping_reg :
		hit_ext ? ext_reg : hit_stage ? stage_reg : 32'h0000_0000;

	// Register writes; mapping bits 31:30 and 7:0, stage bits 31:4 held at zero
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			mapping_reg <= `ACM_MAPPING_RST;
			ext_reg     <= `ACM_EXT_RST;
			stage_reg   <= `ACM_STAGE_RST;
		end
		else if (do_wr)
		begin
			if (hit_map)
				mapping_reg <= reg_req.wdata & `ACM_MAPPING_MASK;
			if (hit_ext)
				ext_reg <= reg_req.wdata;
			if (hit_stage)
				stage_reg <= reg_req.wdata & `ACM_STAGE_MASK;
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rdata_reg  <= 32'h0000_0000;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rdata_reg  <= (reg_valid & ~reg_req.wr) ? rdata_next : rdata_reg;
			rvalid_reg <= reg_valid & ~reg_req.wr;
		end
	end

	// ==========================================================
	// Source selection
	wire logic [SAMPLE_W-1:0] ext_zero = ext_reg[`ACM_EXT0_MSB:`ACM_EXT0_LSB];
	wire logic [SAMPLE_W-1:0] ext_one  = ext_reg[`ACM_EXT1_MSB:`ACM_EXT1_LSB];
	wire logic [7:0] raw1_sel = mapping_reg[`ACM_RAW1_MSB:`ACM_RAW1_LSB];

	// Codes above 3 are undefined; they fall back to the internal raw zero
	wire logic [SAMPLE_W-1:0] chan_one =
		(raw1_sel == 8'h01) ? sd_raw_one :
		(raw1_sel == 8'h02) ? ext_zero :
		(raw1_sel == 8'h03) ? ext_one : sd_raw_zero;
	wire logic [SAMPLE_W-1:0] chan_zero = sd_raw_zero;

	// Phase selection by field code
	function automatic logic [SAMPLE_W-1:0] pick(input logic [1:0] code,
		input logic [SAMPLE_W-1:0] c0, input logic [SAMPLE_W-1:0] c1,
		input logic [SAMPLE_W-1:0] c2);
		logic [SAMPLE_W-1:0] r;
		r = '0;
		unique case (acm_chan_e'(code))
			ACM_CH_ZERO: r = c0;
			ACM_CH_ONE:  r = c1;
			ACM_CH_TWO:  r = c2;
			ACM_CH_RSVD: r = '0;
		endcase
		return r;
	endfunction

	// One selector per phase: slice 0 is UX, 1 is V, 2 is WY, fields two bits apart
	// Packed net, so each loop pass drives only its own slice
	wire logic [2:0][SAMPLE_W-1:0] phase_sel;
	genvar p;
	generate
		for (p = 0; p < 3; p++)
		begin : g_phase
			wire logic [1:0] code = mapping_reg[`ACM_UX_LSB+2*p +: 2];
			assign phase_sel[p] = pick(code, chan_zero, chan_one, current_channel_two);
		end
	endgenerate

	// Registered outputs, one cycle of latency
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			phase_reg      <= '0;
			stage_mode_reg <= ACM_STG_POS_NEG;
		end
		else
		begin
			phase_reg      <= '{ux: phase_sel[0], v: phase_sel[1], wy: phase_sel[2],
				raw_one: chan_one};
			stage_mode_reg <= acm_stage_e'(stage_reg[`ACM_STAGE0_MSB:`ACM_STAGE0_LSB]);
		end
	end

	assign reg_rdata       = rdata_reg;
	assign reg_rvalid      = rvalid_reg;
	assign phase_out       = phase_reg;
	assign stage_zero_mode = stage_mode_reg;

	// ==========================================================
	// Checks
	// Phase routing: the output lags its field and its source by one edge
	a_v_route: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[27:26] == 2'd1 |=> phase_out.v == $past(chan_one))
		else $error("V phase not routed from channel one");
	a_wy_route: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[29:28] == 2'd2 |=> phase_out.wy == $past(current_channel_two))
		else $error("WY phase not routed from channel two");
	a_ux_route: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[25:24] == 2'd0 |=> phase_out.ux == $past(sd_raw_zero))
		else $error("UX phase not routed from channel zero");
	a_ext_zero_wr: assert property (@(posedge ref_clk) disable iff (rst)
		do_wr && hit_ext |=> ext_reg[15:0] == $past(reg_req.wdata[15:0]))
		else $error("External sample zero not stored");
	// Storage only; routing is judged against the select of the same edge below
	a_ext_one_wr: assert property (@(posedge ref_clk) disable iff (rst)
		do_wr && hit_ext |=> ext_reg[31:16] == $past(reg_req.wdata[31:16]))
		else $error("External sample one not stored");
	a_stage_mode: assert property (@(posedge ref_clk) disable iff (rst)
		do_wr && hit_stage |=> ##1 stage_zero_mode == acm_stage_e'($past(reg_req.wdata[3:0], 2)))
		else $error("Input stage mode not applied");
	a_raw_ext_sel: assert property (@(posedge ref_clk) disable iff (rst)
		raw1_sel == 8'h02 |=> phase_out.raw_one == $past(ext_reg[15:0]))
		else $error("Raw channel one not taken from external zero");
	a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[27:26] == 2'd3 |=> phase_out.v == '0)
		else $error("Reserved code did not route zero");
	a_ux_rsvd: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[25:24] == 2'd3 |=> phase_out.ux == '0)
		else $error("Reserved UX code did not route zero");
	a_wy_rsvd: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[29:28] == 2'd3 |=> phase_out.wy == '0)
		else $error("Reserved WY code did not route zero");
	a_ux_one: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[25:24] == 2'd1 |=> phase_out.ux == $past(chan_one))
		else $error("UX phase not routed from channel one");
	a_ux_two: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[25:24] == 2'd2 |=> phase_out.ux == $past(current_channel_two))
		else $error("UX phase not routed from channel two");
	a_v_zero: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[27:26] == 2'd0 |=> phase_out.v == $past(sd_raw_zero))
		else $error("V phase not routed from channel zero");
	a_v_two: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[27:26] == 2'd2 |=> phase_out.v == $past(current_channel_two))
		else $error("V phase not routed from channel two");
	a_wy_zero: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[29:28] == 2'd0 |=> phase_out.wy == $past(sd_raw_zero))
		else $error("WY phase not routed from channel zero");
	a_wy_one: assert property (@(posedge ref_clk) disable iff (rst)
		mapping_reg[29:28] == 2'd1 |=> phase_out.wy == $past(chan_one))
		else $error("WY phase not routed from channel one");

	// Raw channel-one source, internal and external
	a_raw_ext_one: assert property (@(posedge ref_clk) disable iff (rst)
		raw1_sel == 8'h03 |=> phase_out.raw_one == $past(ext_reg[31:16]))
		else $error("Raw channel one not taken from external one");
	a_raw_int_one: assert property (@(posedge ref_clk) disable iff (rst)
		raw1_sel == 8'h01 |=> phase_out.raw_one == $past(sd_raw_one))
		else $error("Raw channel one not taken from internal one");

	// ==========================================================
	// Register port checks; reset clears outputs whatever state came before
	a_reset_clear: assert property (@(posedge ref_clk)
		rst |=> phase_out == '0 && !reg_rvalid && stage_zero_mode == ACM_STG_POS_NEG)
		else $error("Outputs not cleared by reset");
	a_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
		reg_valid && !reg_req.wr |=> reg_rvalid)
		else $error("Read request got no answer");
	a_write_quiet: assert property (@(posedge ref_clk) disable iff (rst)
		reg_valid && reg_req.wr |=> !reg_rvalid)
		else $error("Write request produced a read answer");
	a_read_ext: assert property (@(posedge ref_clk) disable iff (rst)
		reg_valid && !reg_req.wr && hit_ext |=> reg_rdata == $past(ext_reg))
		else $error("External sample register read back wrong");
	// Bits 31:30 and 7:0 must never hold written ones
	a_map_clean: assert property (@(posedge ref_clk) disable iff (rst)
		do_wr && hit_map |=> mapping_reg[31:30] == 2'h0 && mapping_reg[7:0] == 8'h00)
		else $error("Unused mapping bits stored");

endmodule

// file: verif/acm_channel_map_bench.sv
/*
 * Self-checking bench for the current channel mapping block.
 * Assumes acm_pkg is compiled first; samples held steady while routing is judged.
 */
`timescale 1ns/1ps

module acm_channel_map_bench
	import acm_pkg::*;
;
	// ==========================================================
	// Stimulus and observed signals
	logic              ref_clk;
	logic              rst;
	acm_req_s          reg_req;
	logic              reg_valid;
	logic [31:0]       reg_rdata;
	logic              reg_rvalid;
	logic [15:0]       raw_z;
	logic [15:0]       raw_o;
	logic [15:0]       chan_two;
	acm_phase_s        phase_out;
	acm_stage_e        stage_zero_mode;
	int                n_errors;
	int                n_checks;

	acm_channel_map dut (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
		.reg_valid(reg_valid), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.sd_raw_zero(raw_z), .sd_raw_one(raw_o), .current_channel_two(chan_two),
		.phase_out(phase_out), .stage_zero_mode(stage_zero_mode));

	// Free-running 100 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Shared helpers
	task final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Distinct sample levels so a wrong route cannot pass by accident
	function automatic logic [15:0] pick(input int c);
		return (c == 0) ? raw_z : (c == 1) ? raw_o : (c == 2) ? chan_two : 16'h0000;
	endfunction

	task reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_req <= '{1'b1, a, d};
		reg_valid <= 1'b1;
		@(posedge ref_clk);
		reg_valid <= 1'b0;
	endtask

	// Bounded wait on the read answer; a lost answer ends the run
	task check_read(input logic [7:0] a, input logic [31:0] exp);
		bit seen;
		seen = 1'b0;
		@(posedge ref_clk);
		reg_req <= '{1'b0, a, 32'h0000_0000};
		reg_valid <= 1'b1;
		@(posedge ref_clk);
		reg_valid <= 1'b0;
		for (int i = 0; i < 4 && !seen; i++)
		begin
			@(negedge ref_clk);
			seen = (reg_rvalid === 1'b1);
		end
		if (!seen)
		begin
			n_errors++;
			final_report();
		end
		else
			chk("read data", exp, reg_rdata);
	endtask

	// Routing is registered: let a few edges land, then look mid-cycle
	task settle;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	// ==========================================================
	// Scenarios
	task test_reset;
		check_read(8'h0a, 32'h2400_0100);
		check_read(8'h0b, 32'h0000_0000);
		check_read(8'h0c, 32'h0000_0000);
		settle();
		chk("ux", {16'h0000, pick(0)}, {16'h0000, phase_out.ux});
		chk("v", {16'h0000, pick(1)}, {16'h0000, phase_out.v});
		chk("wy", {16'h0000, pick(2)}, {16'h0000, phase_out.wy});
	endtask

	// Every phase code, reserved one included; bits outside 29:8 must not stick
	task test_mapping;
		logic [1:0]  c;
		logic [31:0] w;
		for (int i = 0; i < 4; i++)
		begin
			c = i[1:0];
			w = {2'b11, c, c, c, 24'h00_01ff};
			reg_write(8'h0a, w);
			check_read(8'h0a, w & 32'h3fff_ff00);
			settle();
			chk("ux", {16'h0000, pick(i)}, {16'h0000, phase_out.ux});
			chk("v", {16'h0000, pick(i)}, {16'h0000, phase_out.v});
			chk("wy", {16'h0000, pick(i)}, {16'h0000, phase_out.wy});
		end
	endtask

	// External samples reach the raw channel-one path through codes 2 and 3
	task test_external;
		logic [15:0] exp_raw [4];
		exp_raw = '{raw_z, raw_o, 16'h1234, 16'hbeef};
		reg_write(8'h0b, 32'hbeef_1234);
		check_read(8'h0b, 32'hbeef_1234);
		for (int s = 0; s < 4; s++)
		begin
			reg_write(8'h0a, 32'h2400_0000 | (s << 8));
			settle();
			chk("raw one", {16'h0000, exp_raw[s]}, {16'h0000, phase_out.raw_one});
		end
		// Back to the internal converter once external samples are no longer needed
		reg_write(8'h0a, 32'h2400_0100);
		settle();
		chk("raw one", {16'h0000, raw_o}, {16'h0000, phase_out.raw_one});
	endtask

	// Stage codes, upper bits dropped, unmapped index reads zero
	task test_stage;
		for (int s = 0; s < 5; s++)
		begin
			reg_write(8'h0c, 32'hffff_fff0 | s);
			check_read(8'h0c, s);
			settle();
			chk("stage", s, {28'h000_0000, stage_zero_mode});
		end
		reg_write(8'h3f, 32'h5a5a_5a5a);
		check_read(8'h3f, 32'h0000_0000);
		check_read(8'h0c, 32'h0000_0004);
	endtask

	// Reset in mid-run clears outputs and brings every register back to default
	task test_mid_reset;
		reg_write(8'h0a, 32'h0000_0000);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("phase hi", 32'h0000_0000, phase_out[63:32]);
		chk("phase lo", 32'h0000_0000, phase_out[31:0]);
		chk("stage", 32'h0000_0000, {28'h000_0000, stage_zero_mode});
		@(posedge ref_clk);
		rst <= 1'b0;
		check_read(8'h0a, 32'h2400_0100);
		check_read(8'h0b, 32'h0000_0000);
		check_read(8'h0c, 32'h0000_0000);
		settle();
		chk("v", {16'h0000, pick(1)}, {16'h0000, phase_out.v});
		chk("wy", {16'h0000, pick(2)}, {16'h0000, phase_out.wy});
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		n_errors = 0;
		n_checks = 0;
		rst = 1'b1;
		reg_valid = 1'b0;
		reg_req = '{1'b0, 8'h00, 32'h0000_0000};
		raw_z = 16'h1111;
		raw_o = 16'h2222;
		chan_two = 16'h3333;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		test_reset();
		test_mapping();
		test_external();
		test_stage();
		test_mid_reset();
		final_report();
	end
endmodule
